// [logic/aux_pwm_channel.sv]
// one auxiliary pulse generator: step counter, on-time latch, output level
`timescale 1ns/1ps
module aux_pwm_channel (
   input  wire logic i_sys_clk,
   input  wire logic i_srst,
   pwm_chan_if.chan  bus
);
   import aux_pwm_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] on_latch;
      logic             idle;
      logic             level;
   } chan_state_t;

   chan_state_t cur_reg;
   chan_state_t cur_next;
   logic        start;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      cur_next = cur_reg;
      start    = 1'b0;
      if (bus.restart) begin
         cur_next.count    = '0;
         cur_next.on_latch = bus.ontime;
         cur_next.idle     = bus.sync_en;
      end else if (bus.tick) begin
         start = bus.sync_en ? bus.sync_start : (cur_reg.count == bus.period);
         if (start) begin
            cur_next.count    = '0;
            cur_next.on_latch = bus.ontime;
            cur_next.idle     = 1'b0;
         end else if (cur_reg.count == bus.period) begin
            cur_next.count = '0;
         end else begin
            cur_next.count = cur_reg.count + 1'b1;
         end
      end
      // on-time above the period keeps the compare true all cycle
      cur_next.level = !cur_next.idle && (cur_next.count < cur_next.on_latch);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign bus.count = cur_reg.count;
   assign bus.level = cur_reg.level;
   assign bus.idle  = cur_reg.idle;

   //////////////////////////////////////////////////////////////////////////
   a_full_duty: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (!cur_reg.idle && cur_reg.on_latch > bus.period && cur_reg.count <= bus.period)
      |-> cur_reg.level)
      else $error("on-time above period did not hold output high");

   a_zero_low: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (cur_reg.on_latch == '0) |-> !cur_reg.level)
      else $error("zero on-time let output go high");

   a_cycle_rise: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (bus.tick && !bus.restart && !bus.sync_en && cur_reg.count == bus.period
       && bus.ontime != '0) |=> (cur_reg.level && cur_reg.count == '0))
      else $error("output did not rise at cycle start");

   a_ontime_hold: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (!bus.tick && !bus.restart) |=> $stable(cur_reg.on_latch))
      else $error("on-time latch changed mid cycle");

   a_step_count: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (!bus.sync_en && bus.tick && !bus.restart && cur_reg.count != bus.period)
      |=> cur_reg.count == $past(cur_reg.count) + 1'b1)
      else $error("step counter did not advance by one");

   a_high_time: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      cur_reg.level |-> (cur_reg.count < cur_reg.on_latch))
      else $error("output high past its on-time");

endmodule

// [logic/aux_pwm_pkg.sv]
// shared constants and types of the dual auxiliary pulse-width timer
package aux_pwm_pkg;

   localparam int          DATA_W        = 16;
   localparam int          ADDR_W        = 4;
   localparam int          CNT_W         = 8;

   // register word addresses
   localparam logic [3:0]  MODE_OFS      = 4'h0;
   localparam logic [3:0]  PERIOD0_OFS   = 4'h1;
   localparam logic [3:0]  PERIOD1_OFS   = 4'h2;
   localparam logic [3:0]  ONTIME0_OFS   = 4'h3;
   localparam logic [3:0]  ONTIME1_OFS   = 4'h4;
   localparam logic [3:0]  PINSEL_OFS    = 4'h5;
   localparam logic [3:0]  PIN8_OFS      = 4'h6;
   localparam logic [3:0]  STATUS_OFS    = 4'h7;

   // field positions
   localparam int          MODE_IND_BIT  = 8;
   localparam int          PIN8_SEL_BIT  = 1;
   localparam int          PIN8_DATA_BIT = 0;
   localparam int          PIN7_SEL_BIT  = 7;
   localparam int          ST_LVL0_BIT   = 0;
   localparam int          ST_LVL1_BIT   = 1;
   localparam int          ST_IDLE1_BIT  = 2;

   // reset values
   localparam logic        MODE_RST      = 1'b0;
   localparam logic [7:0]  PERIOD_RST    = 8'hff;
   localparam logic [7:0]  ONTIME_RST    = 8'h00;
   localparam logic [7:0]  PINSEL_RST    = 8'hff;
   localparam logic [1:0]  PIN8_RST      = 2'h2;

   // one time step lasts two core clocks: a hold phase and an advance phase
   localparam int          STEP_CLKS     = 2;
   typedef enum logic [1:0] {
      PH_HOLD = 2'b01,
      PH_ADV  = 2'b10
   } phase_t;

endpackage

// [logic/dual_aux_pwm_timer.sv]
// dual auxiliary pulse-width timer with register port and pin routing
`timescale 1ns/1ps

// What this block does
// - Mode bit 8 set runs the generators independently, clear runs them in offset mode.
// - In independent mode each output takes its period from its own period register.
// - One step is two core clocks and a period lasts two times the register plus one clocks.
// - Each output stays high for two times its on-time register in core clocks.
// - An on-time beyond the period keeps that output high for the whole cycle.
// - In offset mode both outputs share the first period register, each with its own on-time.
// - In offset mode output 1 rises two times the second period register plus one clocks late.
// - Writes are taken any time but a new on-time acts only from the next cycle start.
// - Writing a period register clears the timers and starts fresh cycles at once.
// - Reset selects offset mode, sets both periods to 255 and clears both on-times.
// - Pin 8 carries output 0 only while its select bit 1 is clear.
// - Pin 7 carries output 1 only while its select bit is clear; reset sets all select bits.
module dual_aux_pwm_timer (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_srst,
   input  wire logic [aux_pwm_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [aux_pwm_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output logic      [aux_pwm_pkg::DATA_W-1:0] o_rdata,
   output logic                               o_pulse_out_zero,
   output logic                               o_pulse_out_one,
   output logic                               o_pin_eight,
   output logic                               o_pin_eight_pwm,
   output logic                               o_pin_seven,
   output logic                               o_pin_seven_pwm
);
   import aux_pwm_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // state of the front end

   typedef struct packed {
      logic              mode_ind;
      logic [CNT_W-1:0]  period0;
      logic [CNT_W-1:0]  period1;
      logic [CNT_W-1:0]  ontime0;
      logic [CNT_W-1:0]  ontime1;
      logic [7:0]        pin_sel;
      logic [1:0]        pin8;
      phase_t            phase;
      logic              restart;
      logic [DATA_W-1:0] rdata;
      logic              pulse0;
      logic              pulse1;
      logic              pin8_out;
      logic              pin8_pwm;
      logic              pin7_out;
      logic              pin7_pwm;
   } top_state_t;

   top_state_t st_reg;
   top_state_t st_next;

   pwm_chan_if ch0 ();
   pwm_chan_if ch1 ();

   //////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic top_state_t reset_state();
      top_state_t s;
      s          = '0;
      s.mode_ind = MODE_RST;
      s.period0  = PERIOD_RST;
      s.period1  = PERIOD_RST;
      s.ontime0  = ONTIME_RST;
      s.ontime1  = ONTIME_RST;
      s.pin_sel  = PINSEL_RST;
      s.pin8     = PIN8_RST;
      s.phase    = PH_HOLD;
      s.restart  = 1'b1;
      return s;
   endfunction

   function automatic logic [DATA_W-1:0] byte_word(input logic [7:0] b);
      return {8'h00, b};
   endfunction

   function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                    input top_state_t      s,
                                                    input logic            l0,
                                                    input logic            l1,
                                                    input logic            i1);
      logic [DATA_W-1:0] w;
      w = '0;
      if (a == MODE_OFS) begin
         w[MODE_IND_BIT] = s.mode_ind;
      end else if (a == PERIOD0_OFS) begin
         w = byte_word(s.period0);
      end else if (a == PERIOD1_OFS) begin
         w = byte_word(s.period1);
      end else if (a == ONTIME0_OFS) begin
         w = byte_word(s.ontime0);
      end else if (a == ONTIME1_OFS) begin
         w = byte_word(s.ontime1);
      end else if (a == PINSEL_OFS) begin
         w = byte_word(s.pin_sel);
      end else if (a == PIN8_OFS) begin
         w[1:0] = s.pin8;
      end else if (a == STATUS_OFS) begin
         w[ST_LVL0_BIT]  = l0;
         w[ST_LVL1_BIT]  = l1;
         w[ST_IDLE1_BIT] = i1;
      end
      return w;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // registers, step phase and pin routing

   always_comb begin
      st_next         = st_reg;
      st_next.restart = 1'b0;
      st_next.rdata   = '0;

      case (st_reg.phase)
         PH_HOLD: begin
            st_next.phase = PH_ADV;
         end
         PH_ADV: begin
            st_next.phase = PH_HOLD;
         end
         default: begin
            st_next.phase = PH_HOLD;
         end
      endcase
      if (st_reg.restart) begin
         st_next.phase = PH_HOLD;
      end

      if (i_wr) begin
         if (i_addr == MODE_OFS) begin
            st_next.mode_ind = i_wdata[MODE_IND_BIT];
            st_next.restart  = 1'b1;
         end else if (i_addr == PERIOD0_OFS) begin
            st_next.period0 = i_wdata[CNT_W-1:0];
            st_next.restart = 1'b1;
         end else if (i_addr == PERIOD1_OFS) begin
            st_next.period1 = i_wdata[CNT_W-1:0];
            st_next.restart = 1'b1;
         end else if (i_addr == ONTIME0_OFS) begin
            st_next.ontime0 = i_wdata[CNT_W-1:0];
         end else if (i_addr == ONTIME1_OFS) begin
            st_next.ontime1 = i_wdata[CNT_W-1:0];
         end else if (i_addr == PINSEL_OFS) begin
            st_next.pin_sel = i_wdata[7:0];
         end else if (i_addr == PIN8_OFS) begin
            st_next.pin8 = i_wdata[1:0];
         end
      end

      if (i_rd) begin
         st_next.rdata = read_word(i_addr, st_reg, ch0.level, ch1.level, ch1.idle);
      end

      st_next.pulse0   = ch0.level;
      st_next.pulse1   = ch1.level;
      st_next.pin8_pwm = !st_reg.pin8[PIN8_SEL_BIT];
      st_next.pin7_pwm = !st_reg.pin_sel[PIN7_SEL_BIT];
      if (st_reg.pin8[PIN8_SEL_BIT]) begin
         st_next.pin8_out = st_reg.pin8[PIN8_DATA_BIT];
      end else begin
         st_next.pin8_out = ch0.level;
      end
      if (st_reg.pin_sel[PIN7_SEL_BIT]) begin
         st_next.pin7_out = 1'b0;
      end else begin
         st_next.pin7_out = ch1.level;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st_reg <= reset_state();
      end else begin
         st_reg <= st_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // generator control

   assign ch0.tick       = (st_reg.phase == PH_ADV);
   assign ch0.restart    = st_reg.restart;
   assign ch0.sync_en    = 1'b0;
   assign ch0.sync_start = 1'b0;
   assign ch0.period     = st_reg.period0;
   assign ch0.ontime     = st_reg.ontime0;

   assign ch1.tick       = (st_reg.phase == PH_ADV);
   assign ch1.restart    = st_reg.restart;
   assign ch1.sync_en    = !st_reg.mode_ind;
   assign ch1.period     = st_reg.mode_ind ? st_reg.period1 : st_reg.period0;
   assign ch1.ontime     = st_reg.ontime1;
   // output 1 starts as output 0 leaves count period1; needs period1 below period0
   assign ch1.sync_start = ch0.tick && (ch0.count == st_reg.period1);

   aux_pwm_channel u_chan0 (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .bus       (ch0)
   );

   aux_pwm_channel u_chan1 (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .bus       (ch1)
   );

   assign o_rdata          = st_reg.rdata;
   assign o_pulse_out_zero = st_reg.pulse0;
   assign o_pulse_out_one  = st_reg.pulse1;
   assign o_pin_eight      = st_reg.pin8_out;
   assign o_pin_eight_pwm  = st_reg.pin8_pwm;
   assign o_pin_seven      = st_reg.pin7_out;
   assign o_pin_seven_pwm  = st_reg.pin7_pwm;

   //////////////////////////////////////////////////////////////////////////
   // checks

   a_reset_values: assert property (
      @(posedge i_sys_clk)
      $fell(i_srst) |-> (!st_reg.mode_ind && st_reg.period0 == PERIOD_RST
                         && st_reg.period1 == PERIOD_RST && st_reg.ontime0 == ONTIME_RST
                         && st_reg.ontime1 == ONTIME_RST && st_reg.pin_sel == PINSEL_RST))
      else $error("wrong register values after reset");

   a_period_restart: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && (i_addr == PERIOD0_OFS || i_addr == PERIOD1_OFS))
      |=> st_reg.restart ##1 (ch0.count == '0 && ch1.count == '0 && st_reg.phase == PH_HOLD))
      else $error("period write did not restart the timers");

   a_mode_write: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == MODE_OFS)
      |=> (st_reg.mode_ind == $past(i_wdata[MODE_IND_BIT]) && ch1.sync_en == !st_reg.mode_ind))
      else $error("mode bit did not select the generator mode");

   a_ind_period: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (st_reg.mode_ind && ch1.tick && !ch1.restart && ch1.count == st_reg.period1)
      |=> ch1.count == '0)
      else $error("output 1 period not set by its own register");

   a_step_width: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (ch0.tick && !ch0.restart && !(i_wr && i_addr <= PERIOD1_OFS))
      |=> !ch0.tick ##1 ch0.tick)
      else $error("time step is not two clocks");

   a_offset_share: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (!st_reg.mode_ind && !ch1.idle && ch1.tick && !ch1.restart
       && ch1.count == st_reg.period0 && st_reg.period1 < st_reg.period0)
      |=> ch1.count == '0)
      else $error("offset mode outputs do not share one period");

   a_offset_delay: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (!st_reg.mode_ind && ch0.tick && !ch0.restart && ch0.count == st_reg.period1
       && st_reg.period1 < st_reg.period0)
      |=> (ch1.count == '0 && !ch1.idle && ch0.count == $past(st_reg.period1) + 1'b1))
      else $error("output 1 offset from output 0 is wrong");

   a_pin8_select: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      !st_reg.pin8[PIN8_SEL_BIT] |=> (o_pin_eight == $past(ch0.level) && o_pin_eight_pwm))
      else $error("pin 8 does not carry output 0");

   a_pin8_gpio: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      st_reg.pin8[PIN8_SEL_BIT]
      |=> (o_pin_eight == $past(st_reg.pin8[PIN8_DATA_BIT]) && !o_pin_eight_pwm))
      else $error("pin 8 not given to general I/O");

   a_pin7_select: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      st_reg.pin_sel[PIN7_SEL_BIT] |=> (!o_pin_seven && !o_pin_seven_pwm))
      else $error("pin 7 carries output 1 while general I/O selected");

   a_pin7_route: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      !st_reg.pin_sel[PIN7_SEL_BIT] |=> (o_pin_seven == $past(ch1.level) && o_pin_seven_pwm))
      else $error("pin 7 does not carry output 1");

   a_ontime0_load: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ONTIME0_OFS) |=> st_reg.ontime0 == $past(i_wdata[CNT_W-1:0]))
      else $error("on-time 0 write not taken");

   a_ontime1_load: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == ONTIME1_OFS) |=> st_reg.ontime1 == $past(i_wdata[CNT_W-1:0]))
      else $error("on-time 1 write not taken");

   a_period0_load: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == PERIOD0_OFS) |=> st_reg.period0 == $past(i_wdata[CNT_W-1:0]))
      else $error("period 0 write not taken");

   a_period1_load: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == PERIOD1_OFS) |=> st_reg.period1 == $past(i_wdata[CNT_W-1:0]))
      else $error("period 1 write not taken");

   a_pinsel_load: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == PINSEL_OFS) |=> st_reg.pin_sel == $past(i_wdata[7:0]))
      else $error("pin select write not taken");

   a_pin8_load: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_wr && i_addr == PIN8_OFS) |=> st_reg.pin8 == $past(i_wdata[1:0]))
      else $error("pin 8 select write not taken");

   a_reset_restart: assert property (
      @(posedge i_sys_clk)
      $fell(i_srst) |-> st_reg.restart ##1 (ch0.count == '0 && ch1.count == '0 && ch1.idle))
      else $error("reset did not restart the generators");

   a_pulse_follow: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      1'b1 |=> (o_pulse_out_zero == $past(ch0.level) && o_pulse_out_one == $past(ch1.level)))
      else $error("pulse outputs do not follow the generators");

   a_ind_running: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (st_reg.mode_ind && !st_reg.restart) |-> !ch1.idle)
      else $error("output 1 waits for an offset in independent mode");

   a_offset_wait: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (!st_reg.mode_ind && st_reg.restart) |=> (ch1.idle && !ch1.level))
      else $error("output 1 did not wait for its offset");

endmodule

// [logic/pwm_chan_if.sv]
// link between the register front end and one pulse generator
`timescale 1ns/1ps
interface pwm_chan_if;
   import aux_pwm_pkg::*;
   logic             tick;
   logic             restart;
   logic             sync_en;
   logic             sync_start;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] ontime;
   logic [CNT_W-1:0] count;
   logic             level;
   logic             idle;

   modport ctrl (output tick, restart, sync_en, sync_start, period, ontime,
                 input  count, level, idle);
   modport chan (input  tick, restart, sync_en, sync_start, period, ontime,
                 output count, level, idle);
endinterface

// [tb/dual_aux_pwm_timer_tb.sv]
// self-checking bench of the dual auxiliary pulse-width timer
`timescale 1ns/1ps
module dual_aux_pwm_timer_tb;
   import aux_pwm_pkg::*;

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end

   logic              i_sys_clk;
   logic              i_srst;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata;
   logic              i_wr;
   logic              i_rd;
   logic [DATA_W-1:0] o_rdata;
   logic              o_pulse_out_zero;
   logic              o_pulse_out_one;
   logic              o_pin_eight;
   logic              o_pin_eight_pwm;
   logic              o_pin_seven;
   logic              o_pin_seven_pwm;
   logic [31:0]       per0, per1, high0, high1, rises0, rises1, stamp0, stamp1;
   logic [31:0]       s0, s1;
   logic              ok_a, ok_b;
   int                n_fail, compares, cyc;

   ////////////////////////////////////////////////////////////////////////////////
   // design and loads
   dual_aux_pwm_timer dut (
      .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pulse_out_zero(o_pulse_out_zero),
      .o_pulse_out_one(o_pulse_out_one), .o_pin_eight(o_pin_eight),
      .o_pin_eight_pwm(o_pin_eight_pwm), .o_pin_seven(o_pin_seven),
      .o_pin_seven_pwm(o_pin_seven_pwm));
   pwm_load_model load0 (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_level(o_pulse_out_zero),
      .o_period(per0), .o_high(high0), .o_rises(rises0), .o_rise_stamp(stamp0));
   pwm_load_model load1 (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_level(o_pulse_out_one),
      .o_period(per1), .o_high(high1), .o_rises(rises1), .o_rise_stamp(stamp1));

   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus and measurement tasks
   task automatic finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string nm);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_rd   <= 1'b0;
      #1;
      `CHK(nm, exp, o_rdata)
   endtask

   task automatic wait_rises(input int ch, input int n, input int lim);
      logic [31:0] s;
      int          i;
      s = ch ? rises1 : rises0;
      i = 0;
      while ((ch ? rises1 : rises0) !== s + n && i < lim) begin
         @(posedge i_sys_clk);
         #1;
         i++;
      end
      `CHK("rise count", s + n, ch ? rises1 : rises0)
   endtask

   task automatic measure(input int ch, input logic [31:0] per, input logic [31:0] hi);
      wait_rises(ch, 2, 2000);
      `CHK("period", per, ch ? per1 : per0)
      `CHK("high time", hi, ch ? high1 : high0)
   endtask

   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc >= 30000) begin
         n_fail++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      n_fail = 0; compares = 0; cyc = 0;
      i_srst = 1'b1; i_addr = 4'h0; i_wdata = 16'h0000; i_wr = 1'b0; i_rd = 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      rd_chk(MODE_OFS, 16'h0000, "mode reset");
      rd_chk(PERIOD0_OFS, 16'h00ff, "period0 reset");
      rd_chk(PERIOD1_OFS, 16'h00ff, "period1 reset");
      rd_chk(ONTIME0_OFS, 16'h0000, "ontime0 reset");
      rd_chk(ONTIME1_OFS, 16'h0000, "ontime1 reset");
      rd_chk(PINSEL_OFS, 16'h00ff, "pin select reset");
      rd_chk(PIN8_OFS, 16'h0002, "pin8 reset");
      rd_chk(STATUS_OFS, 16'h0004, "status reset");
      rd_chk(4'h9, 16'h0000, "unmapped read");
      @(posedge i_sys_clk);
      #1;
      `CHK("rdata idle", 16'h0000, o_rdata)
      `CHK("pin8 routed", 1'b0, o_pin_eight_pwm)
      `CHK("pin7 routed", 1'b0, o_pin_seven_pwm)
      $display("test reset values done");

      wr(ONTIME0_OFS, 16'hff02);
      wr(ONTIME1_OFS, 16'h0004);
      wr(PERIOD0_OFS, 16'h0003);
      wr(PERIOD1_OFS, 16'h0005);
      wr(MODE_OFS, 16'h0100);
      rd_chk(ONTIME0_OFS, 16'h0002, "ontime0 readback");
      rd_chk(MODE_OFS, 16'h0100, "mode readback");
      measure(0, 32'h0000_0008, 32'h0000_0004);
      measure(1, 32'h0000_000c, 32'h0000_0008);
      $display("test independent mode done");

      wr(ONTIME0_OFS, 16'h0005);
      wr(ONTIME1_OFS, 16'h0000);
      repeat (30) @(posedge i_sys_clk);
      #1;
      s0 = rises0; s1 = rises1; ok_a = 1'b1; ok_b = 1'b1;
      repeat (40) begin
         @(posedge i_sys_clk);
         #1;
         ok_a &= (o_pulse_out_zero === 1'b1);
         ok_b &= (o_pulse_out_one === 1'b0);
      end
      `CHK("full duty level", 1'b1, ok_a)
      `CHK("full duty edges", s0, rises0)
      `CHK("zero duty level", 1'b1, ok_b)
      `CHK("zero duty edges", s1, rises1)
      $display("test duty limits done");

      wr(ONTIME0_OFS, 16'h0002);
      wr(PERIOD0_OFS, 16'h0007);
      wait_rises(0, 2, 200);
      wr(ONTIME0_OFS, 16'h0006);
      wait_rises(0, 1, 40);
      `CHK("high before update", 32'h0000_0004, high0)
      wait_rises(0, 1, 40);
      `CHK("high after update", 32'h0000_000c, high0)
      $display("test on-time update done");

      wr(MODE_OFS, 16'h0000);
      wr(ONTIME0_OFS, 16'h0003);
      wr(ONTIME1_OFS, 16'h0002);
      wr(PERIOD1_OFS, 16'h0002);
      wr(PERIOD0_OFS, 16'h0007);
      measure(0, 32'h0000_0010, 32'h0000_0006);
      measure(1, 32'h0000_0010, 32'h0000_0004);
      `CHK("offset delay", 32'h0000_0006, stamp1 - stamp0)
      $display("test offset mode done");

      wr(ONTIME0_OFS, 16'h0001);
      wr(PERIOD0_OFS, 16'h00ff);
      wait_rises(0, 1, 600);
      repeat (40) @(posedge i_sys_clk);
      wr(PERIOD0_OFS, 16'h00ff);
      wait_rises(0, 1, 10);
      $display("test period restart done");

      wr(PERIOD1_OFS, 16'h0001);
      wr(PERIOD0_OFS, 16'h0003);
      wr(ONTIME0_OFS, 16'h0002);
      wr(PIN8_OFS, 16'h0001);
      wr(PINSEL_OFS, 16'h007f);
      @(posedge i_sys_clk);
      #1;
      ok_a = 1'b1; ok_b = 1'b1;
      repeat (16) begin
         @(posedge i_sys_clk);
         #1;
         ok_a &= (o_pin_eight === o_pulse_out_zero);
         ok_b &= (o_pin_seven === o_pulse_out_one);
      end
      `CHK("pin8 pwm flag", 1'b1, o_pin_eight_pwm)
      `CHK("pin8 follows out0", 1'b1, ok_a)
      `CHK("pin7 pwm flag", 1'b1, o_pin_seven_pwm)
      `CHK("pin7 follows out1", 1'b1, ok_b)
      wr(PIN8_OFS, 16'h0003);
      wr(PINSEL_OFS, 16'h00ff);
      repeat (3) @(posedge i_sys_clk);
      #1;
      `CHK("pin8 general io", 1'b0, o_pin_eight_pwm)
      `CHK("pin8 data level", 1'b1, o_pin_eight)
      `CHK("pin7 general io", 1'b0, o_pin_seven_pwm)
      `CHK("pin7 level", 1'b0, o_pin_seven)
      $display("test pin routing done");
      finish_test();
   end
endmodule

// [tb/pwm_load_model.sv]
// load seen by one pulse output: measures period, high time and rising edges
`timescale 1ns/1ps
module pwm_load_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic        i_level,
   output logic      [31:0] o_period,
   output logic      [31:0] o_high,
   output logic      [31:0] o_rises,
   output logic      [31:0] o_rise_stamp
);
   logic [31:0] cnt_reg;
   logic [31:0] stamp_reg;
   logic        prev_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // edge detection and cycle counting
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cnt_reg      <= 32'h0000_0000;
         stamp_reg    <= 32'h0000_0000;
         prev_reg     <= 1'b0;
         o_period     <= 32'h0000_0000;
         o_high       <= 32'h0000_0000;
         o_rises      <= 32'h0000_0000;
         o_rise_stamp <= 32'h0000_0000;
      end else begin
         stamp_reg <= stamp_reg + 32'h0000_0001;
         prev_reg  <= i_level;
         cnt_reg   <= cnt_reg + 32'h0000_0001;
         if (i_level && !prev_reg) begin
            o_period     <= cnt_reg;
            cnt_reg      <= 32'h0000_0001;
            o_rises      <= o_rises + 32'h0000_0001;
            o_rise_stamp <= stamp_reg;
         end
         if (!i_level && prev_reg) begin
            o_high <= cnt_reg;
         end
      end
   end
endmodule
